// [rtl/hnsf_buf.sv]
// Purpose: synchronous FIFO buffering nibbles ahead of the silo writer
// Assumes: single clock, push and pop may coincide
// Notes: ready on the fill side drops when full, so the source is stalled
`timescale 1ns/1ns
module hnsf_buf #(
   parameter int unsigned WIDTH = hnsf_pkg::NIBBLE_W,
   parameter int unsigned DEPTH = hnsf_pkg::BUF_DEPTH
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   hnsf_stream_if.snk fill,
   hnsf_stream_if.src drain
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      begin : g_bad
         $error("hnsf_buf needs a power-of-two depth of at least 2");
      end
   endgenerate
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;
   assign fill.ready = (count_r != (AW+1)'(DEPTH));
   assign drain.valid = (count_r != '0);
   assign drain.data = mem[rd_ptr_r];
   assign push = fill.valid & fill.ready;
   assign pop = drain.valid & drain.ready;
   // storage has no reset: only words covered by count_r are ever read
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= fill.data;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop)
         begin
            count_r <= count_r + 1'b1;
         end
         else if (pop && !push)
         begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// [rtl/hnsf_host.sv]
// Purpose: host controller that fills and empties an external 64x4 nibble silo
// Assumes: silo pins are asynchronous to clk_in; all pin inputs are synchronised
// Notes: writer and reader engines run independently; words are buffered
//        on the write side in a 16-word FIFO
//        a reset in mid-read loses the word that the silo has already let go
//        silo flags are read only after their second sync stage
//        the user pop side may stall for as long as it likes
// Summary of operation
// - room flag and write strobe both high: silo captures the nibble
// - silo holds captured word until room flag and strobe both return low
// - data-ready and read strobe high: word removed, data-ready drops
// - silo keeps output data until data-ready and read strobe are low
`timescale 1ns/1ns
module hnsf_host #(
   parameter int unsigned WIDTH = hnsf_pkg::NIBBLE_W,
   parameter int unsigned DEPTH = hnsf_pkg::BUF_DEPTH
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   // user push side
   input wire logic push_valid_in,
   input wire logic [WIDTH-1:0] push_data_in,
   output logic push_ready_out,
   // user pop side
   output logic pop_valid_out,
   output logic [WIDTH-1:0] pop_data_out,
   input wire logic pop_ready_in,
   // silo write pins
   input wire logic input_ready_in,
   output logic shift_in_out,
   output logic [WIDTH-1:0] write_nibble_out,
   // silo read pins
   input wire logic output_ready_in,
   input wire logic [WIDTH-1:0] read_nibble_in,
   output logic shift_out_out
);
   generate
      if (WIDTH != hnsf_pkg::NIBBLE_W)
      begin : g_bad_width
         $error("hnsf_host drives a silo that is exactly four bits wide");
      end
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_bad_depth
         $error("hnsf_host needs a power-of-two buffer depth of at least 2");
      end
      if (hnsf_pkg::SYNC_STAGES != 2)
      begin : g_bad_sync
         $error("hnsf_host synchronises its pins in exactly two stages");
      end
   endgenerate

   // user stream into the buffer, buffer stream into the write engine
   hnsf_stream_if #(.WIDTH(WIDTH)) up_if ();
   hnsf_stream_if #(.WIDTH(WIDTH)) dn_if ();

   assign up_if.valid = push_valid_in;
   assign up_if.data = push_data_in;
   assign push_ready_out = up_if.ready;

   hnsf_buf #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_buf (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .fill(up_if),
      .drain(dn_if)
   );

   // pin synchronisers: first stage feeds only the second
   // the nibble lines cross as a word only because data-ready lags them
   logic ir_meta_r;
   logic ir_sync_r;
   logic or_meta_r;
   logic or_sync_r;
   logic [WIDTH-1:0] rd_meta_r;
   logic [WIDTH-1:0] rd_sync_r;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ir_meta_r <= 1'b0;
         ir_sync_r <= 1'b0;
         or_meta_r <= 1'b0;
         or_sync_r <= 1'b0;
         rd_meta_r <= '0;
         rd_sync_r <= '0;
      end
      else
      begin
         ir_meta_r <= input_ready_in;
         ir_sync_r <= ir_meta_r;
         or_meta_r <= output_ready_in;
         or_sync_r <= or_meta_r;
         rd_meta_r <= read_nibble_in;
         rd_sync_r <= rd_meta_r;
      end
   end

   // write engine, independent of the read engine
   hnsf_pkg::hnsf_wr_state_t wr_state_r;
   logic [WIDTH-1:0] wr_nibble_r;
   logic shift_in_r;
   // the buffer is popped only between handshakes
   assign dn_if.ready = (wr_state_r == hnsf_pkg::WR_IDLE);
   assign write_nibble_out = wr_nibble_r;
   assign shift_in_out = shift_in_r;

   // the strobe only rises from WR_SETUP, so one word goes per handshake
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         wr_state_r <= hnsf_pkg::WR_IDLE;
         wr_nibble_r <= hnsf_pkg::NIBBLE_RST;
         shift_in_r <= hnsf_pkg::STROBE_RST;
      end
      else
      begin
         case (wr_state_r)
            hnsf_pkg::WR_IDLE:
            begin
               // nibble is set up a cycle ahead of the strobe
               if (dn_if.valid)
               begin
                  wr_nibble_r <= dn_if.data;
                  wr_state_r <= hnsf_pkg::WR_SETUP;
               end
            end
            hnsf_pkg::WR_SETUP:
            begin
               // wait for room; a full silo keeps the flag low
               if (ir_sync_r)
               begin
                  shift_in_r <= 1'b1;
                  wr_state_r <= hnsf_pkg::WR_STROBE;
               end
            end
            hnsf_pkg::WR_STROBE:
            begin
               // nibble stays put until the silo drops its room flag
               if (!ir_sync_r)
               begin
                  shift_in_r <= 1'b0;
                  wr_state_r <= hnsf_pkg::WR_IDLE;
               end
            end
            default:
            begin
               // an unknown code ends any half-done handshake
               shift_in_r <= 1'b0;
               wr_state_r <= hnsf_pkg::WR_IDLE;
            end
         endcase
      end
   end

   // read engine
   // one word in hand at a time, so a stalled user also stalls the silo
   hnsf_pkg::hnsf_rd_state_t rd_state_r;
   logic [WIDTH-1:0] pop_data_r;
   logic shift_out_r;
   assign shift_out_out = shift_out_r;
   assign pop_data_out = pop_data_r;
   // the word is offered only once the silo handshake has closed
   assign pop_valid_out = (rd_state_r == hnsf_pkg::RD_DELIVER);

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rd_state_r <= hnsf_pkg::RD_WAIT;
         pop_data_r <= hnsf_pkg::NIBBLE_RST;
         shift_out_r <= hnsf_pkg::STROBE_RST;
      end
      else
      begin
         case (rd_state_r)
            hnsf_pkg::RD_WAIT:
            begin
               // data lines settle before the ready flag, and pass the
               // same two stages, so the sampled word is the presented one
               if (or_sync_r)
               begin
                  pop_data_r <= rd_sync_r;
                  shift_out_r <= 1'b1;
                  rd_state_r <= hnsf_pkg::RD_STROBE;
               end
            end
            hnsf_pkg::RD_STROBE:
            begin
               if (!or_sync_r)
               begin
                  // releasing the strobe lets the next word drop down
                  shift_out_r <= 1'b0;
                  rd_state_r <= hnsf_pkg::RD_DELIVER;
               end
            end
            hnsf_pkg::RD_DELIVER:
            begin
               // an empty silo simply leaves us waiting in RD_WAIT
               if (pop_ready_in)
               begin
                  rd_state_r <= hnsf_pkg::RD_WAIT;
               end
            end
            default:
            begin
               // an unknown code releases the read strobe as well
               shift_out_r <= 1'b0;
               rd_state_r <= hnsf_pkg::RD_WAIT;
            end
         endcase
      end
   end
endmodule

// [rtl/hnsf_pkg.sv]
// Purpose: shared constants for the nibble silo host controller
// Assumes: one 250 MHz clock, asynchronous active-low reset
// Notes: the silo itself sits outside; these describe its pins and our buffer
package hnsf_pkg;
   localparam int unsigned NIBBLE_W = 4;
   localparam int unsigned SILO_DEPTH = 64;
   localparam int unsigned BUF_DEPTH = 16;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [3:0] NIBBLE_RST = 4'h0;
   localparam logic STROBE_RST = 1'b0;
   typedef enum logic [2:0]
   {
      WR_IDLE = 3'b001,
      WR_SETUP = 3'b010,
      WR_STROBE = 3'b100
   } hnsf_wr_state_t;
   typedef enum logic [2:0]
   {
      RD_WAIT = 3'b001,
      RD_STROBE = 3'b010,
      RD_DELIVER = 3'b100
   } hnsf_rd_state_t;
endpackage

// [rtl/hnsf_stream_if.sv]
// Purpose: valid/ready word stream between the host's own modules
// Assumes: both ends on clk_in
// Notes: data is meaningful only while valid is high
`timescale 1ns/1ns
interface hnsf_stream_if #(parameter int unsigned WIDTH = hnsf_pkg::NIBBLE_W);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [verification/hnsf_host_checker.sv]
// Purpose: port-level checks of the silo host
// Assumes: pin inputs pass two sync flops
// Notes: sync delay allowed as 2 or 3 sampled edges
`timescale 1ns/1ns
module hnsf_host_checker #(parameter int unsigned WIDTH = 4) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic push_valid_in,
   input wire logic [WIDTH-1:0] push_data_in,
   input wire logic push_ready_out,
   input wire logic pop_valid_out,
   input wire logic [WIDTH-1:0] pop_data_out,
   input wire logic pop_ready_in,
   input wire logic input_ready_in,
   input wire logic shift_in_out,
   input wire logic [WIDTH-1:0] write_nibble_out,
   input wire logic output_ready_in,
   input wire logic [WIDTH-1:0] read_nibble_in,
   input wire logic shift_out_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   sequence strobe_drop_s;
      ##[1:40] !shift_in_out;
   endsequence
   nibble_hold_a: assert property (shift_in_out |=> !shift_in_out || $stable(write_nibble_out))
      else $error("nibble changed under strobe");
   strobe_room_a: assert property ($rose(shift_in_out) |->
      $past(input_ready_in, 2) || $past(input_ready_in, 3))
      else $error("strobe without room");
   strobe_end_a: assert property ($fell(shift_in_out) |->
      !$past(input_ready_in, 2) || !$past(input_ready_in, 3))
      else $error("strobe dropped early");
   strobe_bound_a: assert property ($rose(shift_in_out) |-> strobe_drop_s)
      else $error("strobe stuck high");
   read_start_a: assert property ($rose(shift_out_out) |->
      $past(output_ready_in, 2) || $past(output_ready_in, 3))
      else $error("read strobe without data");
   read_end_a: assert property ($fell(shift_out_out) |->
      !$past(output_ready_in, 2) || !$past(output_ready_in, 3))
      else $error("read strobe dropped early");
   pop_hold_a: assert property (pop_valid_out && !pop_ready_in |=>
      pop_valid_out && $stable(pop_data_out) && !$rose(shift_out_out))
      else $error("held word lost");
   pop_take_a: assert property (pop_valid_out && pop_ready_in |=> !pop_valid_out)
      else $error("word not removed");
endmodule

// [verification/hnsf_silo_model.sv]
// Purpose: behavioural 64x4 silo on the far side of the host
// Assumes: no clock of its own, fixed internal delays
// Notes: released output data is inverted so stale values cannot pass
`timescale 1ns/1ns
module hnsf_silo_model (
   input wire logic shift_in_in,
   input wire logic [3:0] nibble_in,
   input wire logic shift_out_in,
   output logic room_out,
   output logic ready_out,
   output logic [3:0] nibble_out
);
   logic [3:0] q[$];
   int cnt = 0;
   initial
   begin
      room_out = 1'b1;
      ready_out = 1'b0;
      nibble_out = 4'h0;
   end
   always
   begin
      wait (room_out && shift_in_in);
      q.push_back(nibble_in);
      cnt++;
      #3 room_out = 1'b0;
      wait (!shift_in_in);
      wait (cnt < 64);
      #5 room_out = 1'b1;
   end
   always
   begin
      wait (cnt > 0);
      #7 nibble_out = q[0];
      #8 ready_out = 1'b1;
      wait (shift_out_in);
      void'(q.pop_front());
      cnt--;
      #3 ready_out = 1'b0;
      wait (!shift_out_in);
      #3 nibble_out = ~nibble_out;
   end
endmodule

// [verification/test_hnsf_host.sv]
// Purpose: self-checking bench of the silo host with a silo model
// Assumes: 250 MHz clock, inputs driven 1 ns after the edge
// Notes: capacity is 64 silo + 16 buffer + one word in each engine
`timescale 1ns/1ns
module test_hnsf_host;
   logic clk_in = 0, rstn_in = 0, push_valid_in = 0, pop_ready_in = 0;
   logic [3:0] push_data_in = 4'h0, d;
   wire push_ready_out, pop_valid_out, shift_in_out, shift_out_out;
   wire input_ready_in, output_ready_in;
   wire [3:0] pop_data_out, write_nibble_out, read_nibble_in;
   int fails = 0, total_checks = 0;
   // upper nibble is pushed, lower nibble is the word that should come back
   logic [7:0] rows [6] = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h33, 8'hcc};
   always #2 clk_in = ~clk_in;
   hnsf_host hnsf_host_i (.clk_in, .rstn_in, .push_valid_in, .push_data_in, .push_ready_out,
      .pop_valid_out, .pop_data_out, .pop_ready_in, .input_ready_in, .shift_in_out,
      .write_nibble_out, .output_ready_in, .read_nibble_in, .shift_out_out);
   hnsf_silo_model hnsf_silo_model_i (.shift_in_in(shift_in_out), .nibble_in(write_nibble_out),
      .shift_out_in(shift_out_out), .room_out(input_ready_in), .ready_out(output_ready_in),
      .nibble_out(read_nibble_in));
   task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // valid and ready are left high between calls so back-to-back words need no re-raise;
   // ready is looked at 1 ns after an edge, where it stands until the next edge
   task push(input logic [3:0] v);
      int n;
      n = 0;
      push_valid_in = 1'b1;
      push_data_in = v;
      while (push_ready_out !== 1'b1 && n < 400)
      begin
         n++;
         @(posedge clk_in);
         #1;
      end
      @(posedge clk_in);
      #1;
      chk("push taken", 4'(n < 400), 4'h1);
   endtask
   // the word is read while it stands, then taken at the next edge
   task pop(output logic [3:0] v);
      int n;
      n = 0;
      pop_ready_in = 1'b1;
      while (pop_valid_out !== 1'b1 && n < 400)
      begin
         n++;
         @(posedge clk_in);
         #1;
      end
      v = pop_data_out;
      chk("pop taken", 4'(n < 400), 4'h1);
      @(posedge clk_in);
      #1;
   endtask
   initial
   begin
      repeat (4) @(posedge clk_in);
      #1 chk("reset flags", {push_ready_out, pop_valid_out, shift_in_out, shift_out_out}, 4'h8);
      chk("reset nibbles", write_nibble_out | pop_data_out, 4'h0);
      @(posedge clk_in);
      #1 rstn_in = 1'b1;
      foreach (rows[i])
      begin
         push(rows[i][7:4]);
         push_valid_in = 1'b0;
         pop(d);
         chk("row out", d, rows[i][3:0]);
      end
      pop_ready_in = 1'b0;
      // fill all 82 places while the user side stalls, then expect a refusal
      for (int i = 0; i < 82; i++) push(4'(i));
      push_valid_in = 1'b0;
      repeat (300) @(posedge clk_in);
      #1 chk("full refuses", 4'(push_ready_out), 4'h0);
      for (int i = 0; i < 82; i++)
      begin
         pop(d);
         chk("drain order", d, 4'(i));
      end
      pop_ready_in = 1'b0;
      repeat (100) @(posedge clk_in);
      #1 chk("empty idle", {pop_valid_out, shift_out_out, output_ready_in, 1'b0}, 4'h0);
      // reset in mid-run while idle: nibbles held 4'h1 before, so clearing is visible
      rstn_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk("reset again flags", {push_ready_out, pop_valid_out, shift_in_out, shift_out_out}, 4'h8);
      chk("reset again nibbles", write_nibble_out | pop_data_out, 4'h0);
      rstn_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 chk("after release", {push_ready_out, pop_valid_out, shift_in_out, shift_out_out}, 4'h8);
      push(4'h9);
      push_valid_in = 1'b0;
      pop(d);
      chk("word after reset", d, 4'h9);
      pop_ready_in = 1'b0;
      report_and_stop();
   end
   // watchdog: the run needs a few thousand cycles, this allows about 25,000
   initial
   begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule
bind hnsf_host hnsf_host_checker #(.WIDTH(WIDTH)) chk_i (.clk_in, .rstn_in, .push_valid_in,
   .push_data_in, .push_ready_out, .pop_valid_out, .pop_data_out, .pop_ready_in, .input_ready_in,
   .shift_in_out, .write_nibble_out, .output_ready_in, .read_nibble_in, .shift_out_out);
